/* src/mic_cfg.svh */
// Register map, field positions and reset values of the interpolating integrator-comb filter
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH

// Register byte offsets
`define MIC_CTRL_OFS     8'h00
`define MIC_STAT_OFS     8'h04
`define MIC_OCNT_OFS     8'h08

// Control fields
`define MIC_CTRL_DEC_BIT 0
`define MIC_CTRL_CLR_BIT 1
`define MIC_CTRL_RST     1'h0

// Status field width
`define MIC_CNT_W        16

// Default shape of the filter
`define MIC_DEF_IW       16
`define MIC_DEF_CH       4
`define MIC_DEF_N        4
`define MIC_DEF_I        5
`define MIC_DEF_M        1

// Widest words the stream structs carry
`define MIC_IN_MAX       32
`define MIC_OUT_MAX      64
`define MIC_CH_MAX       8

`endif

/* src/mic_pkg.sv */
// Types shared by the interpolating integrator-comb filter
`include "mic_cfg.svh"

package mic_pkg;

	// Input stream word: qualifier, channel tag, sample
	typedef struct packed {
		logic                          valid;
		logic [`MIC_CH_MAX-1:0]        chan;
		logic signed [`MIC_IN_MAX-1:0] data;
	} mic_in_t;

	// Output stream word: qualifier, channel tag, full-precision sample
	typedef struct packed {
		logic                           valid;
		logic [`MIC_CH_MAX-1:0]         chan;
		logic signed [`MIC_OUT_MAX-1:0] data;
	} mic_out_t;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} mic_wb_req_t;

endpackage

/* src/mic_top.sv */
// Multichannel interpolating integrator-comb filter with Wishbone control
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "mic_cfg.svh"

// Functional notes
// - Each channel outputs I samples per input sample.
// - I-1 zeros follow every accepted sample before integration.
// - Interpolation factors below two are refused at elaboration.
// - Channel count is a parameter; every channel has its own state.
// - N integrator stages and N comb stages.
// - Each comb subtracts its input from M samples earlier, same channel.
// - Interpolation factor is a fixed integer parameter.
// - Optional final decimation halves the output rate.
// - Final decimation just drops every second output of a channel.
// - Input sample is accepted only when its valid is high.
// - Input channel tag selects the state that the sample updates.
// - Input width comes from the source; one lane carries all channels.
// - Output width keeps full precision; no rounding or saturation.
// - Bypass outputs zero-stuffed input times the filter gain.
// - Output valid marks every cycle carrying a true sample.
// - Output channel tag names the channel of each output sample.
module mic_top
#(
	parameter int IW = `MIC_DEF_IW,
	parameter int CH = `MIC_DEF_CH,
	parameter int N  = `MIC_DEF_N,
	parameter int I  = `MIC_DEF_I,
	parameter int M  = `MIC_DEF_M
)
(
	input  wire logic                mclk,
	input  wire logic                nrst,
	input  wire mic_pkg::mic_wb_req_t wb_req,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	input  wire mic_pkg::mic_in_t    din,
	input  wire logic                bypass,
	output mic_pkg::mic_out_t        dout
);
	import mic_pkg::*;

	// ==========================================================
	// Derived widths and constants
	// full-precision growth
	localparam int OW  = IW + N * $clog2(I * M) + 1;
	localparam int CW  = (CH > 1) ? $clog2(CH) : 1;
	localparam int PW  = $clog2(I);
	// Bypass gain (I*M)^N / I matches the DC gain of the filtered path
	localparam int GN  = ((I * M) ** N) / I;
	localparam logic signed [OW-1:0] GAIN = OW'(GN);
	localparam logic [PW-1:0] PH_LAST = PW'(I - 1);

	// fixed integer factor of two or more
	// Refused at elaboration so a bad shape never builds silently
	if (I < 2 || N < 1 || M < 1 || CH < 1 || IW < 2)
	begin
		$error("mic_top: unsupported filter shape");
	end
	// Widths must fit the fixed stream carriers of the package
	if (IW > `MIC_IN_MAX || OW > `MIC_OUT_MAX || CW > `MIC_CH_MAX)
	begin
		$error("mic_top: widths exceed stream carriers");
	end

	// ==========================================================
	// Wishbone register slave
	logic                  dec_en_r;
	logic                  clr_r;
	logic [`MIC_CNT_W-1:0] ovr_cnt_r;
	logic [`MIC_CNT_W-1:0] out_cnt_r;
	logic                  wb_hit;

	// Ack low keeps a held request from being taken twice
	assign wb_hit = wb_req.cyc && wb_req.stb && !wb_ack_o;

	// One registered answer a cycle after the request, released the cycle after
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_hit;
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			wb_dat_o <= 32'h0;
		else if (wb_hit && !wb_req.we)
		begin
			unique case (wb_req.adr)
				`MIC_CTRL_OFS: wb_dat_o <= {31'h0, dec_en_r};
				`MIC_STAT_OFS: wb_dat_o <= {16'h0, ovr_cnt_r};
				`MIC_OCNT_OFS: wb_dat_o <= {16'h0, out_cnt_r};
				default:       wb_dat_o <= 32'h0;
			endcase
		end
	end

	// Control writes; clear bit self-clears after one cycle
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			dec_en_r <= `MIC_CTRL_RST;
			clr_r    <= 1'b0;
		end
		else
		begin
			clr_r <= 1'b0;
			if (wb_hit && wb_req.we && wb_req.adr == `MIC_CTRL_OFS && wb_req.sel[0])
			begin
				dec_en_r <= wb_req.dat[`MIC_CTRL_DEC_BIT];
				clr_r    <= wb_req.dat[`MIC_CTRL_CLR_BIT];
			end
		end
	end

	// ==========================================================
	// Input acceptance and comb section
	// per-channel history
	logic signed [OW-1:0] cdl [CH][N][M];
	logic signed [OW-1:0] cstg [N+1];
	logic signed [OW-1:0] in_ext;
	logic [CW-1:0]        in_ch;
	logic                 busy_r;
	logic [PW-1:0]        ph_r;
	logic                 take;
	logic                 drop;

	assign in_ext = OW'(din.data[IW-1:0]) | ({OW{din.data[IW-1]}} << IW);
	// Only the low tag bits address a channel
	assign in_ch  = din.chan[CW-1:0];
	// accept only qualified words with the stuffer free or in its last slot
	// No ready line: an early word is dropped and counted, never stalled
	assign take   = din.valid && (!busy_r || ph_r == PH_LAST) && !clr_r;
	assign drop   = din.valid && !take;

	// comb cascade against the channel's own history
	always_comb
	begin
		cstg[0] = in_ext;
		// Oldest history word sits at index M-1
		for (int s = 0; s < N; s++)
			cstg[s+1] = cstg[s] - cdl[in_ch][s][M-1];
	end

	// combs step only once per input sample
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cdl <= '{default: '0};
		else if (clr_r)
			cdl <= '{default: '0};
		else if (take)
		begin
			for (int s = 0; s < N; s++)
			begin
				cdl[in_ch][s][0] <= cstg[s];
				for (int d = 1; d < M; d++)
					cdl[in_ch][s][d] <= cdl[in_ch][s][d-1];
			end
		end
	end

	// ==========================================================
	// Zero stuffer: one channel at a time, I output slots each
	logic signed [OW-1:0] cv_r;
	logic signed [OW-1:0] raw_r;
	logic [CW-1:0]        cur_ch_r;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_r   <= 1'b0;
			ph_r     <= '0;
			cv_r     <= '0;
			raw_r    <= '0;
			cur_ch_r <= '0;
		end
		else if (clr_r)
		begin
			busy_r <= 1'b0;
			ph_r   <= '0;
		end
		else if (take)
		begin
			busy_r   <= 1'b1;
			ph_r     <= '0;
			cv_r     <= cstg[N];
			raw_r    <= in_ext;
			cur_ch_r <= in_ch;
		end
		else if (busy_r)
		begin
			busy_r <= (ph_r != PH_LAST);
			ph_r   <= ph_r + PW'(1);
		end
	end

	// ==========================================================
	// Integrator section, one step per output slot
	logic signed [OW-1:0] integ [CH][N];
	logic signed [OW-1:0] istg [N+1];
	logic signed [OW-1:0] stuffed;

	// Slot 0 carries the comb result, later slots the stuffed zeros
	assign stuffed = (ph_r == '0) ? cv_r : '0;

	always_comb
	begin
		istg[0] = stuffed;
		for (int s = 0; s < N; s++)
			istg[s+1] = istg[s] + integ[cur_ch_r][s];
	end

	// Accumulators may wrap; the comb differences taken upstream keep the result exact
	// wrap-around accumulation at output rate
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			integ <= '{default: '0};
		else if (clr_r)
			integ <= '{default: '0};
		else if (busy_r)
		begin
			for (int s = 0; s < N; s++)
				integ[cur_ch_r][s] <= istg[s+1];
		end
	end

	// ==========================================================
	// Final halving and output register
	logic [CH-1:0] odd_r;
	logic          keep;
	logic          emit;

	// every second slot of a channel is discarded
	assign keep = !dec_en_r || !odd_r[cur_ch_r];
	// One decode for output valid and the counter, so they never disagree
	assign emit = busy_r && keep && !clr_r;

	// Per-channel parity, so interleaved channels halve independently
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			odd_r <= '0;
		else if (clr_r)
			odd_r <= '0;
		else if (busy_r && dec_en_r)
			odd_r[cur_ch_r] <= ~odd_r[cur_ch_r];
	end

	// Output word; data is loaded every cycle, valid or not
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			dout <= '0;
		else
		begin
			dout.valid <= emit;
			dout.chan  <= `MIC_CH_MAX'(cur_ch_r);
			// bypass: stuffed input times gain
			// Product cast alone so it widens signed, not zero-filled
			if (bypass && ph_r == '0)
				dout.data <= `MIC_OUT_MAX'(raw_r * GAIN);
			else if (bypass)
				dout.data <= '0;
			else
				dout.data <= `MIC_OUT_MAX'(istg[N]);
		end
	end

	// Status counters, wrapping; dropped inputs show as overruns
	// Wrapping keeps the path short; software takes differences
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ovr_cnt_r <= '0;
			out_cnt_r <= '0;
		end
		else
		begin
			if (drop)
				ovr_cnt_r <= ovr_cnt_r + `MIC_CNT_W'(1);
			if (emit)
				out_cnt_r <= out_cnt_r + `MIC_CNT_W'(1);
		end
	end

endmodule

/* tb/mic_checker.sv */
// Port assertions for the interpolating filter
`timescale 1ns/1ps
module mic_checker
#(
	parameter int CH = 4,
	parameter int I  = 5
)
(
	input wire logic                 mclk,
	input wire logic                 nrst,
	input wire mic_pkg::mic_wb_req_t wb_req,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	input wire mic_pkg::mic_in_t     din,
	input wire logic                 bypass,
	input wire mic_pkg::mic_out_t    dout
);
	import mic_pkg::*;
	logic [7:0] gap_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ==========
	// Helper
	// Cycles since the last offered input, saturating so it never wraps
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			gap_r <= 8'hff;
		else if (din.valid)
			gap_r <= 8'h0;
		else if (gap_r != 8'hff)
			gap_r <= gap_r + 8'h1;
	// ==========
	// Assertions
	sequence s_take;
		wb_req.cyc && wb_req.stb && !wb_ack_o;
	endsequence
	sequence s_clear;
		wb_ack_o && wb_req.we && wb_req.adr == 8'h00 && wb_req.sel[0] && wb_req.dat[1];
	endsequence
	a_ack_next_cycle: assert property (s_take |=> wb_ack_o) else $error("ack late");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_unmapped_reads_zero:
		assert property (wb_ack_o && !wb_req.we && wb_req.adr > 8'h08 |-> wb_dat_o == 32'h0) else $error("bad read");
	a_out_after_input:
		assert property (dout.valid |-> gap_r <= 8'(I + 1)) else $error("output without input");
	a_out_chan_range:
		assert property (dout.valid |-> dout.chan < CH) else $error("channel out of range");
	a_out_chan_match:
		assert property ($rose(dout.valid) && $past(din.valid, 2) |-> dout.chan == $past(din.chan, 2))
		else $error("channel mismatch");
	a_clear_quiets:
		assert property (s_clear |-> ##2 !dout.valid) else $error("valid after clear");
	a_bypass_zero_slot:
		assert property (bypass && $past(bypass) && $past(bypass, 2) && dout.valid && $past(dout.valid)
			&& !$past(din.valid, 2) |-> dout.data == 64'h0) else $error("stuffed slot not zero");
endmodule
bind mic_top mic_checker #(.CH(CH), .I(I)) i_chk (.mclk(mclk), .nrst(nrst), .wb_req(wb_req),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din(din), .bypass(bypass), .dout(dout));

/* tb/mic_src.sv */
// Upstream sample source feeding the filter
`timescale 1ns/1ps
module mic_src
(
	input  wire logic        mclk,
	output mic_pkg::mic_in_t din
);
	import mic_pkg::*;
	// Idle word starts at zero
	initial din = '0;
	// Qualified tagged word
	// Junk stays on tag and data when idle, so a sink must honour valid
	task automatic send(input logic [7:0] ch, input logic [31:0] x);
		@(posedge mclk);
		din <= '{valid: 1'b1, chan: ch, data: x};
		@(posedge mclk);
		din <= '{valid: 1'b0, chan: ~ch, data: ~x};
	endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the interpolating filter
`timescale 1ns/1ps
module tb;
	import mic_pkg::*;
	typedef struct {int ch; int x; logic byp;} mic_row_t;
	localparam int I    = 5;
	localparam int GAIN = (I ** 4) / I;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        bypass = 1'b0;
	mic_wb_req_t wb_req = '0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	mic_in_t     din;
	mic_out_t    dout;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          check_count = 0;
	int          nv;
	int          h [5] = '{1, 4, 10, 20, 35};
	mic_row_t    rows [4] = '{'{0, 3, 1'b0}, '{1, -2, 1'b0}, '{2, 100, 1'b1}, '{3, -32768, 1'b0}};
	mic_top #(.I(I)) i_dut (.mclk(mclk), .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .din(din), .bypass(bypass), .dout(dout));
	mic_src i_src (.mclk(mclk), .din(din));
	// Clock, 25 ns period
	always #12.5 mclk = ~mclk;
	// ==========
	// Tasks
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// Classic cycle; held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		@(posedge mclk);
		// Waits as long as the slave takes; only the watchdog ends a hang
		while (wb_ack_o !== 1'b1)
			@(posedge mclk);
		rd = wb_dat_o;
		wb_req <= '0;
		@(posedge mclk);
	endtask
	// Gathers one burst mid-cycle; step 0 skips the data check, 2 follows kept slots
	task automatic grab(input int ch, input int x, input logic byp, input int step);
		int k;
		k = 0;
		nv = 0;
		repeat (12)
		begin
			@(negedge mclk);
			if (dout.valid === 1'b1)
			begin
				nv++;
				chk(dout.chan, 64'(ch));
				if (step != 0)
					chk(dout.data, byp ? 64'(k == 0 ? x * GAIN : 0) : 64'(x * h[k]));
				k += step;
			end
		end
		@(posedge mclk);
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// Sequence
	// Each row lands on a fresh channel, so independence shows too
	initial
	begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		foreach (rows[r])
		begin
			bypass <= rows[r].byp;
			i_src.send(rows[r].ch, rows[r].x);
			grab(rows[r].ch, rows[r].x, rows[r].byp, 1);
			chk(nv, I);
		end
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h14);
		wb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 8'h00, 32'h3);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		i_src.send(0, 1);
		grab(0, 1, 1'b0, 2);
		chk(nv, 3);
		i_src.send(0, 1);
		grab(0, 1, 1'b0, 0);
		chk(nv, 2);
		wb(1'b1, 8'h00, 32'h2);
		i_src.send(1, 5);
		// Second word lands while the stuffer is busy; watch the burst meanwhile
		fork
			i_src.send(1, 9);
			grab(1, 5, 1'b0, 1);
		join
		chk(nv, I);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, 8'h00, 32'h1);
		i_src.send(2, 7);
		repeat (3) @(posedge mclk);
		nrst <= 1'b0;
		@(negedge mclk);
		chk(dout.valid, 1'b0);
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		tally_and_finish();
	end
	// Cuts a hang short; the run needs under two hundred cycles
	initial
	begin
		repeat (2000) @(posedge mclk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
